// [shared/idcr_consts.vh]
`ifndef IDCR_CONSTS_VH
`define IDCR_CONSTS_VH

// ****************************************************
// Register indices; the byte address is four times the index.
// ****************************************************
`define IDCR_ADDR_W 8
`define IDCR_IDX_TF0 8'hc6
`define IDCR_IDX_TF1 8'hc7
`define IDCR_IDX_TF2 8'hc8
`define IDCR_IDX_TF3 8'hc9
`define IDCR_IDX_DA0 8'hca
`define IDCR_IDX_DA1 8'hcb
`define IDCR_IDX_DA2 8'hcc
`define IDCR_IDX_DA3 8'hcd
`define IDCR_IDX_DW0 8'hce
`define IDCR_IDX_DW1 8'hcf
`define IDCR_IDX_PAUSE 8'hd3
`define IDCR_IDX_STOP 8'hd4

// ****************************************************
// Field layout and reset values.
// ****************************************************
`define IDCR_BYTE_RST 8'h00
`define IDCR_DW1_MASK 8'h1f
`define IDCR_DW1_W 5
`define IDCR_WIDTH_W 13
`define IDCR_CTRL_BIT 0
`define IDCR_WORD_ZERO 32'h0000_0000
`define IDCR_BYTE_LANE 0

// ****************************************************
// Bus handshake states.
// ****************************************************
`define IDCR_ST_IDLE 2'h0
`define IDCR_ST_ANSWER 2'h1
`define IDCR_ST_DONE 2'h2

`endif

// [logic/idcr_regs.v]
`timescale 1ns/1ps
`include "idcr_consts.vh"

module idcr_regs
(
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire [`IDCR_ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire dec_start,
   input wire dec_is_video,
   input wire video_done,
   output reg [31:0] xfer_count,
   output reg [31:0] dest_start_address,
   output reg [`IDCR_WIDTH_W-1:0] dest_image_width,
   output reg still_active,
   output reg video_active,
   output reg video_paused,
   output reg video_stop
);

   // ****************************************************
   // Reset release.
   // ****************************************************
   reg rst_meta_r;
   reg rst_n_r;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // ****************************************************
   // Helpers.
   // ****************************************************
   function [7:0] merge_byte;
      input [7:0] old_val;
      input lane_en;
      input [7:0] new_val;
      begin
         merge_byte = lane_en ? new_val : old_val;
      end
   endfunction

   function hit;
      input [`IDCR_ADDR_W-1:0] addr;
      input [`IDCR_ADDR_W-1:0] idx;
      begin
         hit = (addr == idx);
      end
   endfunction

   // ****************************************************
   // Register storage.
   // ****************************************************
   reg [7:0] tf0_r;
   reg [7:0] tf1_r;
   reg [7:0] tf2_r;
   reg [7:0] tf3_r;
   reg [7:0] da0_r;
   reg [7:0] da1_r;
   reg [7:0] da2_r;
   reg [7:0] da3_r;
   reg [7:0] dw0_r;
   reg [`IDCR_DW1_W-1:0] dw1_r;
   reg pause_r;
   reg stop_r;
   reg [1:0] st_r;
   reg [1:0] st_nxt;
   reg [31:0] rdata_nxt;
   wire lane0;
   wire commit_wr;
   wire [7:0] wbyte;

   localparam [1:0] ST_IDLE = `IDCR_ST_IDLE;
   localparam [1:0] ST_ANSWER = `IDCR_ST_ANSWER;
   localparam [1:0] ST_DONE = `IDCR_ST_DONE;

   assign lane0 = avs_byteenable[`IDCR_BYTE_LANE];
   assign wbyte = avs_writedata[7:0];
   // A write lands only at the edge where the master sees waitrequest low.
   assign commit_wr = ce && avs_write && !avs_read && (st_r == ST_ANSWER);

   // ****************************************************
   // Bus handshake: one wait cycle, then the answer.
   // ****************************************************
   always @*
   begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE:
         begin
            if (avs_read || avs_write)
               st_nxt = ST_ANSWER;
         end
         ST_ANSWER:
         begin
            st_nxt = ST_DONE;
         end
         ST_DONE:
         begin
            st_nxt = ST_IDLE;
         end
         default:
         begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // Unmapped indices read as zero and swallow writes.
   always @*
   begin
      rdata_nxt = `IDCR_WORD_ZERO;
      if (hit(avs_address, `IDCR_IDX_TF0))
         rdata_nxt[7:0] = tf0_r;
      else if (hit(avs_address, `IDCR_IDX_TF1))
         rdata_nxt[7:0] = tf1_r;
      else if (hit(avs_address, `IDCR_IDX_TF2))
         rdata_nxt[7:0] = tf2_r;
      else if (hit(avs_address, `IDCR_IDX_TF3))
         rdata_nxt[7:0] = tf3_r;
      else if (hit(avs_address, `IDCR_IDX_DA0))
         rdata_nxt[7:0] = da0_r;
      else if (hit(avs_address, `IDCR_IDX_DA1))
         rdata_nxt[7:0] = da1_r;
      else if (hit(avs_address, `IDCR_IDX_DA2))
         rdata_nxt[7:0] = da2_r;
      else if (hit(avs_address, `IDCR_IDX_DA3))
         rdata_nxt[7:0] = da3_r;
      else if (hit(avs_address, `IDCR_IDX_DW0))
         rdata_nxt[7:0] = dw0_r;
      else if (hit(avs_address, `IDCR_IDX_DW1))
         rdata_nxt[`IDCR_DW1_W-1:0] = dw1_r;
      else if (hit(avs_address, `IDCR_IDX_PAUSE))
         rdata_nxt[`IDCR_CTRL_BIT] = pause_r;
      else if (hit(avs_address, `IDCR_IDX_STOP))
         rdata_nxt[`IDCR_CTRL_BIT] = stop_r;
   end

   always @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         st_r <= ST_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= `IDCR_WORD_ZERO;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
         // Keep ce high through a transfer: waitrequest is a flop and would hold low while frozen.
         avs_waitrequest <= (st_nxt != ST_ANSWER);
         if (st_nxt == ST_ANSWER)
            avs_readdata <= rdata_nxt;
      end
   end

   // ****************************************************
   // Byte registers.
   // ****************************************************
   always @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         tf0_r <= `IDCR_BYTE_RST;
         tf1_r <= `IDCR_BYTE_RST;
         tf2_r <= `IDCR_BYTE_RST;
         tf3_r <= `IDCR_BYTE_RST;
         da0_r <= `IDCR_BYTE_RST;
         da1_r <= `IDCR_BYTE_RST;
         da2_r <= `IDCR_BYTE_RST;
         da3_r <= `IDCR_BYTE_RST;
         dw0_r <= `IDCR_BYTE_RST;
         dw1_r <= {`IDCR_DW1_W{1'b0}};
      end
      else if (commit_wr)
      begin
         if (hit(avs_address, `IDCR_IDX_TF0))
            tf0_r <= merge_byte(tf0_r, lane0, wbyte);
         else if (hit(avs_address, `IDCR_IDX_TF1))
            tf1_r <= merge_byte(tf1_r, lane0, wbyte);
         else if (hit(avs_address, `IDCR_IDX_TF2))
            tf2_r <= merge_byte(tf2_r, lane0, wbyte);
         else if (hit(avs_address, `IDCR_IDX_TF3))
            tf3_r <= merge_byte(tf3_r, lane0, wbyte);
         else if (hit(avs_address, `IDCR_IDX_DA0))
            da0_r <= merge_byte(da0_r, lane0, wbyte);
         else if (hit(avs_address, `IDCR_IDX_DA1))
            da1_r <= merge_byte(da1_r, lane0, wbyte);
         else if (hit(avs_address, `IDCR_IDX_DA2))
            da2_r <= merge_byte(da2_r, lane0, wbyte);
         else if (hit(avs_address, `IDCR_IDX_DA3))
            da3_r <= merge_byte(da3_r, lane0, wbyte);
         else if (hit(avs_address, `IDCR_IDX_DW0))
            dw0_r <= merge_byte(dw0_r, lane0, wbyte);
         else if (hit(avs_address, `IDCR_IDX_DW1) && lane0)
            dw1_r <= wbyte[`IDCR_DW1_W-1:0];
      end
   end

   // ****************************************************
   // Video controls.
   // ****************************************************
   wire pause_wr;
   wire stop_wr;
   wire video_start;

   assign pause_wr = commit_wr && lane0 && hit(avs_address, `IDCR_IDX_PAUSE);
   assign stop_wr = commit_wr && lane0 && hit(avs_address, `IDCR_IDX_STOP) && wbyte[`IDCR_CTRL_BIT];
   assign video_start = ce && dec_start && dec_is_video;

   always @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         pause_r <= 1'b0;
         stop_r <= 1'b0;
      end
      else if (ce)
      begin
         // Pause is a stored level that stop clears, so software can arm it before playback.
         if (pause_wr)
            pause_r <= wbyte[`IDCR_CTRL_BIT];
         else if (stop_r)
            pause_r <= 1'b0;
         // Stop is held for one cycle only; a written zero changes nothing.
         if (stop_wr)
            stop_r <= 1'b1;
         else
            stop_r <= 1'b0;
      end
   end

   // ****************************************************
   // Decode session and outputs.
   // ****************************************************
   always @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         xfer_count <= `IDCR_WORD_ZERO;
         dest_start_address <= `IDCR_WORD_ZERO;
         dest_image_width <= {`IDCR_WIDTH_W{1'b0}};
         still_active <= 1'b0;
         video_active <= 1'b0;
         video_paused <= 1'b0;
         video_stop <= 1'b0;
      end
      else if (ce)
      begin
         // The values are sampled once at the start, so later partial writes are harmless.
         if (dec_start)
         begin
            xfer_count <= {tf3_r, tf2_r, tf1_r, tf0_r};
            if (dec_is_video)
            begin
               dest_start_address <= `IDCR_WORD_ZERO;
               dest_image_width <= {`IDCR_WIDTH_W{1'b0}};
            end
            else
            begin
               dest_start_address <= {da3_r, da2_r, da1_r, da0_r};
               dest_image_width <= {dw1_r, dw0_r};
            end
         end
         still_active <= dec_start ? !dec_is_video : (still_active && !video_done);
         if (stop_r)
            video_active <= 1'b0;
         else if (video_start)
            video_active <= 1'b1;
         else if (video_done)
            video_active <= 1'b0;
         video_paused <= pause_r && !stop_r;
         video_stop <= stop_r;
      end
   end

endmodule // idcr_regs

// [tb/idcr_props.sv]
`timescale 1ns/1ps
`include "idcr_consts.vh"
// ****
// Bus and decoder checks.
// ****
module idcr_chk
(
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire [`IDCR_ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire dec_start,
   input wire dec_is_video,
   input wire video_done,
   input wire [31:0] xfer_count,
   input wire [31:0] dest_start_address,
   input wire [12:0] dest_image_width,
   input wire still_active,
   input wire video_active,
   input wire video_paused,
   input wire video_stop
);
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("wait low too long");
read_answer_a: assert property ($rose(avs_read) |-> ##[1:2] !avs_waitrequest) else $error("no answer");
high_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
width_top_a: assert property (!avs_waitrequest && avs_read && avs_address == `IDCR_IDX_DW1
   |-> avs_readdata[7:5] == 3'h0) else $error("width top bits set");
count_hold_a: assert property (!dec_start |=> $stable(xfer_count)) else $error("count moved");
video_dest_a: assert property (dec_start && dec_is_video |=> dest_start_address == 32'h0
   && dest_image_width == 13'h0 && video_active) else $error("video start wrong");
still_go_a: assert property (dec_start && !dec_is_video |=> still_active) else $error("still not active");
pause_go_a: assert property (avs_write && !avs_waitrequest && avs_address == `IDCR_IDX_PAUSE
   && avs_byteenable[0] && avs_writedata[0] |-> ##[1:2] video_paused) else $error("no pause");
stop_go_a: assert property (avs_write && !avs_waitrequest && avs_address == `IDCR_IDX_STOP
   && avs_byteenable[0] && avs_writedata[0] |-> ##[1:2] video_stop) else $error("no stop");
stop_end_a: assert property (video_stop |-> !video_active && !video_paused ##1 !video_stop)
   else $error("stop wrong");
pause_clear_a: assert property (avs_write && !avs_waitrequest && avs_address == `IDCR_IDX_PAUSE
   && avs_byteenable[0] && !avs_writedata[0] |-> ##2 !video_paused) else $error("pause not cleared");
stop_zero_a: assert property (avs_write && !avs_waitrequest && avs_address == `IDCR_IDX_STOP
   && avs_byteenable[0] && !avs_writedata[0] |-> ##2 !video_stop) else $error("stop on zero");
endmodule // idcr_chk
bind idcr_regs idcr_chk u_chk (.*);

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "idcr_consts.vh"
// ****
// Register bank bench.
// ****
module testbench;
reg clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, dec_start = 1'b0, dec_is_video = 1'b0;
reg video_done = 1'b0, dd = 1'b0;
reg [7:0] avs_address = 8'h00;
reg [31:0] avs_writedata = 32'h0;
reg [3:0] avs_byteenable = 4'hf;
wire [31:0] avs_readdata, xfer_count, dest_start_address;
wire [12:0] dest_image_width;
wire avs_waitrequest, still_active, video_active, video_paused, video_stop;
reg [7:0] m [0:255];
reg [31:0] q [$];
reg [15:0] s = 16'h9d50;
integer error_cnt = 0, check_count = 0, cyc = 0, i;
always #20 clk = ~clk;
idcr_regs u_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dec_start(dec_start),
   .dec_is_video(dec_is_video), .video_done(video_done), .xfer_count(xfer_count),
   .dest_start_address(dest_start_address), .dest_image_width(dest_image_width),
   .still_active(still_active), .video_active(video_active), .video_paused(video_paused), .video_stop(video_stop));
function [15:0] nx(input [15:0] v);
   nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction
function [7:0] msk(input [7:0] a);
   msk = (a >= 8'hc6 && a <= 8'hce) ? 8'hff : (a == 8'hcf) ? 8'h1f : (a == 8'hd3) ? 8'h01 : 8'h00;
endfunction
task complete_run;
begin
   $display("checks %0d errors %0d", check_count, error_cnt);
   if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
   else
      $display("Test failed");
   $finish;
end
endtask
task chk(input [31:0] g, input [31:0] e);
begin
   check_count = check_count + 1;
   if (g !== e)
   begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %h expected %h", $time, g, e);
   end
end
endtask
// Unmapped places and the self-clearing stop bit mirror as zero.
task bus(input w, input [7:0] a, input [7:0] d, input [3:0] be);
begin
   s = nx(s);
   avs_address <= a;
   avs_write <= w;
   avs_read <= !w;
   avs_writedata <= {s, s[7:0], d};
   avs_byteenable <= be;
   if (w && be[0])
      m[a] = d & msk(a);
   if (!w)
      q.push_back({24'h0, m[a]});
   do @(posedge clk); while (avs_waitrequest !== 1'b0);
   avs_write <= 1'b0;
   avs_read <= 1'b0;
   @(posedge clk);
end
endtask
task dec(input v);
begin
   q.push_back({m[8'hc9], m[8'hc8], m[8'hc7], m[8'hc6]});
   q.push_back(v ? 32'h0 : {m[8'hcd], m[8'hcc], m[8'hcb], m[8'hca]});
   q.push_back(v ? 32'h0000_2000 : {17'h0, 2'b10, m[8'hcf][4:0], m[8'hce]});
   dec_is_video <= v;
   dec_start <= 1'b1;
   @(posedge clk);
   dec_start <= 1'b0;
   repeat (3) @(posedge clk);
end
endtask
always @(posedge clk)
begin
   cyc <= cyc + 1;
   dd <= dec_start;
   if (avs_read && avs_waitrequest === 1'b0)
      chk(avs_readdata, q.pop_front());
   if (dd)
   begin
      chk(xfer_count, q.pop_front());
      chk(dest_start_address, q.pop_front());
      chk({17'h0, still_active, video_active, dest_image_width}, q.pop_front());
   end
   if (cyc == 5000)
   begin
      error_cnt = error_cnt + 1;
      complete_run;
   end
end
initial
begin
   for (i = 0; i < 256; i = i + 1)
      m[i] = 8'h00;
   repeat (12) @(posedge clk);
   nrst <= 1'b1;
   repeat (4) @(posedge clk);
   for (i = 8'hc0; i < 8'hd6; i = i + 1)
      bus(1'b0, i[7:0], 8'h00, 4'hf);
   $display("reset values done");
   for (i = 8'hc6; i < 8'hd0; i = i + 1)
   begin
      bus(1'b1, i[7:0], s[7:0], 4'hf);
      bus(1'b0, i[7:0], 8'h00, 4'hf);
   end
   bus(1'b1, 8'hce, 8'h5a, 4'he);
   bus(1'b0, 8'hce, 8'h00, 4'hf);
   bus(1'b1, 8'hc3, 8'hff, 4'hf);
   bus(1'b0, 8'hc3, 8'h00, 4'hf);
   $display("read write done");
   dec(1'b0);
   video_done <= 1'b1;
   @(posedge clk);
   video_done <= 1'b0;
   dec(1'b1);
   bus(1'b1, 8'hd3, 8'h01, 4'hf);
   bus(1'b0, 8'hd3, 8'h00, 4'hf);
   bus(1'b1, 8'hd3, 8'h00, 4'hf);
   bus(1'b0, 8'hd3, 8'h00, 4'hf);
   bus(1'b1, 8'hd3, 8'h01, 4'hf);
   bus(1'b1, 8'hd4, 8'h00, 4'hf);
   bus(1'b0, 8'hd3, 8'h00, 4'hf);
   bus(1'b1, 8'hd4, 8'h01, 4'hf);
   m[8'hd3] = 8'h00;
   bus(1'b0, 8'hd3, 8'h00, 4'hf);
   $display("decode and video done");
   complete_run;
end
endmodule // testbench
